// *** vssc_sync_top.v ***
// Raster timing, screen/border/cursor enables and sync outputs
//
// Contract
// - Display end before display start: no video requests, border over whole screen.
// - Border start after border end: no border or cursor, cursor requests continue.
// - Cursor end below cursor start: no cursor and no cursor requests.
// - Flyback high from raster after display end to first display raster.
// - Each colour channel driven from a 4-bit linear code.
// - Revision one inverts DAC codes; revision two drives them straight.
// - Red nibble goes out inverted through a sub-pixel shifter.
// - High-res cursor pixel: 00 transparent, 01 black, 11 white.
// - High-res cursor shape 4-pixel grain, position to one pixel.
// - Overlay select low when shown colour has bit 12, aligned with outputs.
// - Resync high resets vertical counters, horizontal untouched.
// - Control bit 7 puts XNOR of syncs on vertical sync pin.
// - Odd field sync on raster (N+1)/2, delayed by half raster.
// - Odd field inserts one dummy raster after vertical sync.
`default_nettype none
`include "vssc_consts.vh"
module vssc_sync_top (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pixel sources
  input wire [12:0] videoColour,
  input wire [1:0] cursorPixel,
  input wire [12:0] cursorColour,
  input wire extResync,
  // Display outputs
  output reg [3:0] redOut_ff,
  output reg [3:0] greenOut_ff,
  output reg [3:0] blueOut_ff,
  output wire [3:0] hires_nibble_out,
  output reg overlay_select_n_ff,
  output reg hsyncN_ff,
  output reg vert_or_composite_sync_ff,
  output reg vertical_retrace_flag_ff,
  output reg videoRequest_ff,
  output reg cursorRequest_ff
);
  localparam TW = `VSSC_TW;
  // Register file
  reg [TW-1:0] hCycle_ff, hSyncW_ff, hBStart_ff, hDStart_ff, hDEnd_ff, hBEnd_ff;
  reg [TW-1:0] hCursor_ff, interlace_offset_reg_ff;
  reg [TW-1:0] vCycle_ff, vSyncW_ff, vert_border_start_ff, vert_display_start_ff;
  reg [TW-1:0] vert_display_end_ff, vert_border_end_ff, vert_cursor_start_ff;
  reg [TW-1:0] vert_cursor_end_ff;
  reg [31:0] ctrl_ff;
  reg [12:0] border_ff;
  // Raster counters
  reg [TW-1:0] hCount_ff, vCount_ff;
  reg [1:0] subPix_ff;
  reg oddField_ff, dummyRaster_ff, vSync_ff, hSync_ff;
  reg [12:0] shown_ff;
  reg [3:0] redCode_ff;
  reg showSup_ff;
  // Write channel holding latches
  reg awHeld_ff, wHeld_ff;
  reg [7:0] awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;

  wire hiresMode = ctrl_ff[`VSSC_CTRL_HIRES];
  wire ilaceMode = ctrl_ff[`VSSC_CTRL_ILACE];
  wire dacRev2 = ctrl_ff[`VSSC_CTRL_REV2];
  wire lineEnd = (hCount_ff == hCycle_ff);
  wire halfLine = (hCount_ff == interlace_offset_reg_ff);

  // Enables from programmed vertical windows
  wire screenOn = !(vert_display_end_ff < vert_display_start_ff);
  wire borderOn = !(vert_border_start_ff > vert_border_end_ff);
  wire cursorOn = !(vert_cursor_end_ff < vert_cursor_start_ff);
  wire vDisp = screenOn && (vCount_ff >= vert_display_start_ff) &&
    (vCount_ff <= vert_display_end_ff) && !dummyRaster_ff;
  wire vBord = borderOn && (vCount_ff >= vert_border_start_ff) &&
    (vCount_ff <= vert_border_end_ff);
  wire vCurs = cursorOn && (vCount_ff >= vert_cursor_start_ff) &&
    (vCount_ff <= vert_cursor_end_ff);
  wire hDisp = (hCount_ff >= hDStart_ff) && (hCount_ff < hDEnd_ff);
  wire hBord = (hCount_ff >= hBStart_ff) && (hCount_ff < hBEnd_ff);
  // Cursor is 32 logical pixels; in hires the grain is 4 fine pixels
  wire [TW-1:0] curOff = hCount_ff - hCursor_ff;
  wire hCurs = (hCount_ff >= hCursor_ff) && (curOff < `VSSC_CURSOR_W);
  wire nxtVSync = (vCount_ff <= vSyncW_ff);

  // Horizontal and vertical counters
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hCount_ff <= 10'h000;
      vCount_ff <= 10'h000;
      oddField_ff <= 1'b0;
      dummyRaster_ff <= 1'b0;
      subPix_ff <= 2'h0;
    end else begin
      subPix_ff <= hCursor_ff[1:0];
      hCount_ff <= lineEnd ? 10'h000 : hCount_ff + 10'h001;
      // Resync leaves the horizontal counter alone
      if (extResync) begin
        vCount_ff <= 10'h000;
        oddField_ff <= ilaceMode;
        dummyRaster_ff <= 1'b0;
      end else if (lineEnd) begin
        if (dummyRaster_ff) begin
          dummyRaster_ff <= 1'b0; // Repeat raster, count held
        end else if (vCount_ff == vCycle_ff) begin
          vCount_ff <= 10'h000;
          oddField_ff <= ilaceMode && !oddField_ff;
        end else begin
          vCount_ff <= vCount_ff + 10'h001;
          if (ilaceMode && oddField_ff && vCount_ff == vSyncW_ff)
            dummyRaster_ff <= 1'b1;
        end
      end
    end
  end

  // Syncs; odd field vertical sync shifts by half a raster
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hSync_ff <= 1'b0;
      vSync_ff <= 1'b0;
      hsyncN_ff <= 1'b1;
      vert_or_composite_sync_ff <= 1'b1;
    end else begin
      hSync_ff <= (hCount_ff < hSyncW_ff);
      if (ilaceMode && oddField_ff) begin
        if (halfLine)
          vSync_ff <= nxtVSync;
      end else if (hCount_ff == 10'h000) begin
        vSync_ff <= nxtVSync;
      end
      hsyncN_ff <= !hSync_ff;
      if (ctrl_ff[`VSSC_CTRL_CSYNC])
        vert_or_composite_sync_ff <= ~(vSync_ff ^ hSync_ff);
      else
        vert_or_composite_sync_ff <= !vSync_ff;
    end
  end

  // Colour select, flyback, requests
  reg [12:0] nxt_shown;
  always @* begin
    nxt_shown = 13'h0000;
    if (hDisp && vDisp)
      nxt_shown = videoColour;
    else if (hBord && vBord && !vDisp)
      nxt_shown = border_ff;
    else if (hBord && vBord)
      nxt_shown = border_ff;
    else if (hDisp && !screenOn && vBord)
      nxt_shown = border_ff;
    // Cursor never shows outside the border window
    if (hCurs && vCurs && hBord && vBord && cursorPixel != `VSSC_CUR_TRANSP) begin
      if (hiresMode) begin
        case (cursorPixel)
          `VSSC_CUR_BLACK: nxt_shown = {cursorColour[12], 12'h000};
          `VSSC_CUR_WHITE: nxt_shown = {cursorColour[12], 12'h00F};
          default: nxt_shown = nxt_shown;
        endcase
      end else begin
        nxt_shown = cursorColour;
      end
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shown_ff <= 13'h0000;
      vertical_retrace_flag_ff <= 1'b1;
      videoRequest_ff <= 1'b0;
      cursorRequest_ff <= 1'b0;
    end else begin
      shown_ff <= nxt_shown;
      // Flag changes only at raster start
      if (hCount_ff == 10'h000)
        vertical_retrace_flag_ff <= !vDisp;
      videoRequest_ff <= screenOn && vDisp && hBord;
      cursorRequest_ff <= cursorOn && vCurs && hSync_ff;
    end
  end

  // DAC stage, polarity per revision; overlay aligned with DAC
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      redOut_ff <= 4'h0;
      greenOut_ff <= 4'h0;
      blueOut_ff <= 4'h0;
      redCode_ff <= 4'h0;
      showSup_ff <= 1'b0;
      overlay_select_n_ff <= 1'b1;
    end else begin
      redCode_ff <= shown_ff[3:0];
      redOut_ff <= dacRev2 ? shown_ff[3:0] : ~shown_ff[3:0];
      greenOut_ff <= dacRev2 ? shown_ff[7:4] : ~shown_ff[7:4];
      blueOut_ff <= dacRev2 ? shown_ff[11:8] : ~shown_ff[11:8];
      showSup_ff <= shown_ff[`VSSC_SUP_BIT];
      overlay_select_n_ff <= !shown_ff[`VSSC_SUP_BIT];
    end
  end

  // Nibble path shares the DAC stage latency
  vssc_hires_shifter u_shift (
    .clock(clock),
    .resetn(resetn),
    .redIn(shown_ff[3:0]),
    .subShift(subPix_ff),
    .nibble_ff(hires_nibble_out)
  );

  // AXI write: address and data taken in either order
  wire wrGo = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VSSC_RESP_OK;
    end else begin
      s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrGo) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_ff[7:2] > `VSSC_OFF_BORDER >> 2 ||
          awAddr_ff[1:0] != 2'h0) ? `VSSC_RESP_SLVERR : `VSSC_RESP_OK;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte-lane merge of incoming write data
  wire [31:0] wMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}},
    {8{wStrb_ff[0]}}};
  reg [31:0] oldVal;
  always @* begin
    case (awAddr_ff)
      `VSSC_OFF_CTRL: oldVal = ctrl_ff;
      `VSSC_OFF_BORDER: oldVal = {19'h00000, border_ff};
      default: oldVal = 32'h00000000;
    endcase
  end
  wire [31:0] newVal = (wData_ff & wMask) | (oldVal & ~wMask);

  // Register updates; software is trusted to write in flyback
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hCycle_ff <= `VSSC_RST_HCYCLE;
      hSyncW_ff <= 10'h000;
      hBStart_ff <= 10'h000;
      hDStart_ff <= 10'h000;
      hDEnd_ff <= 10'h000;
      hBEnd_ff <= 10'h000;
      hCursor_ff <= 10'h000;
      interlace_offset_reg_ff <= 10'h000;
      vCycle_ff <= `VSSC_RST_VCYCLE;
      vSyncW_ff <= 10'h000;
      vert_border_start_ff <= 10'h000;
      vert_display_start_ff <= 10'h001;
      vert_display_end_ff <= 10'h000;
      vert_border_end_ff <= 10'h000;
      vert_cursor_start_ff <= 10'h001;
      vert_cursor_end_ff <= 10'h000;
      ctrl_ff <= `VSSC_RST_ZERO;
      border_ff <= 13'h0000;
    end else if (wrGo) begin
      case (awAddr_ff)
        `VSSC_OFF_HCYCLE: hCycle_ff <= newVal[TW-1:0];
        `VSSC_OFF_HSYNCW: hSyncW_ff <= newVal[TW-1:0];
        `VSSC_OFF_HBSTART: hBStart_ff <= newVal[TW-1:0];
        `VSSC_OFF_HDSTART: hDStart_ff <= newVal[TW-1:0];
        `VSSC_OFF_HDEND: hDEnd_ff <= newVal[TW-1:0];
        `VSSC_OFF_HBEND: hBEnd_ff <= newVal[TW-1:0];
        `VSSC_OFF_HCURS: hCursor_ff <= newVal[TW-1:0];
        `VSSC_OFF_ILACE: interlace_offset_reg_ff <= newVal[TW-1:0];
        `VSSC_OFF_VCYCLE: vCycle_ff <= newVal[TW-1:0];
        `VSSC_OFF_VSYNCW: vSyncW_ff <= newVal[TW-1:0];
        `VSSC_OFF_VBSTART: vert_border_start_ff <= newVal[TW-1:0];
        `VSSC_OFF_VDSTART: vert_display_start_ff <= newVal[TW-1:0];
        `VSSC_OFF_VDEND: vert_display_end_ff <= newVal[TW-1:0];
        `VSSC_OFF_VBEND: vert_border_end_ff <= newVal[TW-1:0];
        `VSSC_OFF_VCSTART: vert_cursor_start_ff <= newVal[TW-1:0];
        `VSSC_OFF_VCEND: vert_cursor_end_ff <= newVal[TW-1:0];
        `VSSC_OFF_CTRL: ctrl_ff <= newVal;
        `VSSC_OFF_BORDER: border_ff <= newVal[12:0];
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // AXI read: one cycle ready, data the next
  reg [31:0] rdVal;
  reg rdErr;
  always @* begin
    rdErr = 1'b0;
    case (s_axi_araddr)
      `VSSC_OFF_HCYCLE: rdVal = {22'h000000, hCycle_ff};
      `VSSC_OFF_HSYNCW: rdVal = {22'h000000, hSyncW_ff};
      `VSSC_OFF_HBSTART: rdVal = {22'h000000, hBStart_ff};
      `VSSC_OFF_HDSTART: rdVal = {22'h000000, hDStart_ff};
      `VSSC_OFF_HDEND: rdVal = {22'h000000, hDEnd_ff};
      `VSSC_OFF_HBEND: rdVal = {22'h000000, hBEnd_ff};
      `VSSC_OFF_HCURS: rdVal = {22'h000000, hCursor_ff};
      `VSSC_OFF_ILACE: rdVal = {22'h000000, interlace_offset_reg_ff};
      `VSSC_OFF_VCYCLE: rdVal = {22'h000000, vCycle_ff};
      `VSSC_OFF_VSYNCW: rdVal = {22'h000000, vSyncW_ff};
      `VSSC_OFF_VBSTART: rdVal = {22'h000000, vert_border_start_ff};
      `VSSC_OFF_VDSTART: rdVal = {22'h000000, vert_display_start_ff};
      `VSSC_OFF_VDEND: rdVal = {22'h000000, vert_display_end_ff};
      `VSSC_OFF_VBEND: rdVal = {22'h000000, vert_border_end_ff};
      `VSSC_OFF_VCSTART: rdVal = {22'h000000, vert_cursor_start_ff};
      `VSSC_OFF_VCEND: rdVal = {22'h000000, vert_cursor_end_ff};
      `VSSC_OFF_CTRL: rdVal = ctrl_ff;
      `VSSC_OFF_BORDER: rdVal = {19'h00000, border_ff};
      // Live raster state for software polling flyback
      `VSSC_OFF_STATUS: rdVal = {12'h000, vertical_retrace_flag_ff, oddField_ff,
        dummyRaster_ff, vSync_ff, vCount_ff, 6'h00};
      `VSSC_OFF_PIXIN: rdVal = {14'h0000, showSup_ff, redCode_ff, shown_ff};
      default: begin
        rdVal = 32'h00000000;
        rdErr = 1'b1;
      end
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `VSSC_RESP_OK;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdVal;
        s_axi_rresp <= rdErr ? `VSSC_RESP_SLVERR : `VSSC_RESP_OK;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** vssc_consts.vh ***
// Constants for the video screen sync control block
`ifndef VSSC_CONSTS_VH
`define VSSC_CONSTS_VH
// AXI4-Lite register byte offsets
`define VSSC_OFF_HCYCLE 8'h00
`define VSSC_OFF_HSYNCW 8'h04
`define VSSC_OFF_HBSTART 8'h08
`define VSSC_OFF_HDSTART 8'h0C
`define VSSC_OFF_HDEND 8'h10
`define VSSC_OFF_HBEND 8'h14
`define VSSC_OFF_HCURS 8'h18
`define VSSC_OFF_ILACE 8'h1C
`define VSSC_OFF_VCYCLE 8'h20
`define VSSC_OFF_VSYNCW 8'h24
`define VSSC_OFF_VBSTART 8'h28
`define VSSC_OFF_VDSTART 8'h2C
`define VSSC_OFF_VDEND 8'h30
`define VSSC_OFF_VBEND 8'h34
`define VSSC_OFF_VCSTART 8'h38
`define VSSC_OFF_VCEND 8'h3C
`define VSSC_OFF_CTRL 8'h40
`define VSSC_OFF_BORDER 8'h44
`define VSSC_OFF_STATUS 8'h48
`define VSSC_OFF_PIXIN 8'h4C
`define VSSC_ADDR_W 8
// Field widths and positions
`define VSSC_TW 10
`define VSSC_COLW 13
`define VSSC_CURSOR_W 10'h020
`define VSSC_SUP_BIT 12
`define VSSC_CTRL_CSYNC 7
`define VSSC_CTRL_ILACE 6
`define VSSC_CTRL_HIRES 8
`define VSSC_CTRL_REV2 9
// Reset values
`define VSSC_RST_HCYCLE 10'h0FF
`define VSSC_RST_VCYCLE 10'h137
`define VSSC_RST_ZERO 32'h00000000
// AXI responses
`define VSSC_RESP_OK 2'h0
`define VSSC_RESP_SLVERR 2'h2
// Cursor pixel codes
`define VSSC_CUR_TRANSP 2'h0
`define VSSC_CUR_BLACK 2'h1
`define VSSC_CUR_UNUSED 2'h2
`define VSSC_CUR_WHITE 2'h3
`define VSSC_NIB_BLACK 4'h0
`define VSSC_NIB_WHITE 4'hF
`endif

// *** vssc_hires_shifter.v ***
// Sub-pixel shifter feeding the inverted high-resolution nibble pins
`default_nettype none
`include "vssc_consts.vh"
module vssc_hires_shifter (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Pixel stream
  input wire [3:0] redIn,
  input wire [1:0] subShift,
  // Nibble out
  output reg [3:0] nibble_ff
);
  reg [3:0] prev_ff;
  wire [7:0] pair = {redIn, prev_ff};
  reg [3:0] nxt_nibble;

  // Select a 4-bit window across two pixels, then invert
  always @* begin
    case (subShift)
      2'h0: nxt_nibble = pair[7:4];
      2'h1: nxt_nibble = pair[6:3];
      2'h2: nxt_nibble = pair[5:2];
      default: nxt_nibble = pair[4:1];
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= 4'h0;
      nibble_ff <= 4'hF;
    end else begin
      prev_ff <= redIn;
      nibble_ff <= ~nxt_nibble;
    end
  end
endmodule
`default_nettype wire

// *** vssc_sync_asserts.sv ***
// Port assertions for the video sync control block
`default_nettype none
`include "vssc_consts.vh"
module vssc_sync_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Pixel path
  input wire logic [12:0] videoColour,
  input wire logic [12:0] cursorColour,
  input wire logic [3:0] redOut_ff,
  input wire logic [3:0] hires_nibble_out,
  input wire logic overlay_select_n_ff,
  input wire logic vertical_retrace_flag_ff,
  input wire logic videoRequest_ff,
  input wire logic cursorRequest_ff
);
  logic cfg_ff, sup_ff, rev2_ff, quiet;
  logic [2:0] since_ff;
  // Shadow of bus writes; address and data are offered together, so data is valid here
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= 1'b0;
      sup_ff <= 1'b0;
      rev2_ff <= 1'b0;
      since_ff <= 3'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      cfg_ff <= 1'b1;
      since_ff <= 3'h0;
      if (s_axi_awaddr == `VSSC_OFF_BORDER) sup_ff <= s_axi_wdata[12];
      if (s_axi_awaddr == `VSSC_OFF_CTRL) rev2_ff <= s_axi_wdata[9];
    end else if (since_ff != 3'h7) begin
      since_ff <= since_ff + 3'h1;
    end
  end
  // Settled: the pixel pipeline has flushed since the last write or reset
  assign quiet = since_ff[2];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn early");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid)
    else $error("no write response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data after address");
  screen_off_a: assert property (!cfg_ff |-> !videoRequest_ff)
    else $error("video request with screen off");
  cursor_off_a: assert property (!cfg_ff |-> !cursorRequest_ff)
    else $error("cursor request with cursor off");
  flyback_idle_a: assert property (!cfg_ff |-> vertical_retrace_flag_ff)
    else $error("flyback low without display");
  overlay_cause_a: assert property (quiet && !sup_ff && !overlay_select_n_ff |->
    $past(videoColour[12], 2) || $past(cursorColour[12], 2))
    else $error("overlay select without bit 12");
  nibble_invert_a: assert property (quiet |->
    hires_nibble_out == (rev2_ff ? ~redOut_ff : redOut_ff))
    else $error("nibble not inverted red data");
endmodule
bind vssc_sync_top vssc_sync_asserts i_chk (.clock(clock), .resetn(resetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .videoColour(videoColour), .cursorColour(cursorColour), .redOut_ff(redOut_ff),
  .hires_nibble_out(hires_nibble_out), .overlay_select_n_ff(overlay_select_n_ff),
  .vertical_retrace_flag_ff(vertical_retrace_flag_ff), .videoRequest_ff(videoRequest_ff),
  .cursorRequest_ff(cursorRequest_ff));
`default_nettype wire

// *** vssc_far_model.sv ***
// Far-side model: pixel serialiser and external resync source
`default_nettype none
module vssc_far_model (
  // Pixel clock
  input wire logic clock,
  // From the block and the bench
  input wire logic [3:0] nibble,
  input wire logic resyncReq,
  // To the block, and the serial pixel line
  output logic extResync,
  output logic serialBit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pulse_ff = 2'h0;
  // Two-pixel pulse, far shorter than any raster
  always @(posedge clock) begin
    if (resyncReq) pulse_ff <= 2'h2;
    else if (pulse_ff != 2'h0) pulse_ff <= pulse_ff - 2'h1;
  end
  assign extResync = (pulse_ff != 2'h0);
  // Four bits per pixel at four times the pixel rate, bit 0 leaving first
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      serialBit <= #(i) nibble[i];
    end
  end
endmodule
`default_nettype wire

// *** test_video_screen_sync_control.sv ***
// Self-checking bench for the video sync control block
`default_nettype none
`include "vssc_consts.vh"
module test_video_screen_sync_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, resyncReq = 1'b0, monOn = 1'b0, hiresOn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h3AFB2D7E, rdata;
  logic [12:0] videoColour = 13'h0, cursorColour = 13'h0;
  logic [1:0] cursorPixel = 2'h0, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, extResync;
  logic overlayN, hsyncN, syncPin, flyback, vreq, creq, prevPin;
  logic [3:0] redOut, greenOut, blueOut, nibble;
  logic [11:0] colWant;
  int num_errors = 0, total_checks = 0, vreqN, creqN, flyLowN, edgeN, redN, supN;
  logic [7:0] cfgA [16] = '{`VSSC_OFF_HCYCLE, `VSSC_OFF_HSYNCW, `VSSC_OFF_HBSTART,
    `VSSC_OFF_HDSTART, `VSSC_OFF_HDEND, `VSSC_OFF_HBEND, `VSSC_OFF_HCURS, `VSSC_OFF_VCYCLE,
    `VSSC_OFF_VSYNCW, `VSSC_OFF_VBSTART, `VSSC_OFF_VBEND, `VSSC_OFF_VCSTART,
    `VSSC_OFF_VCEND, `VSSC_OFF_BORDER, `VSSC_OFF_VDSTART, `VSSC_OFF_VDEND};
  logic [31:0] cfgD [16] = '{32'h3F, 32'h8, 32'hC, 32'h10, 32'h30, 32'h34, 32'h14, 32'h9,
    32'h1, 32'h2, 32'h7, 32'h4, 32'h5, 32'h10A5, 32'h3, 32'h6};

  vssc_sync_top i_dut (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .videoColour(videoColour), .cursorPixel(cursorPixel), .cursorColour(cursorColour),
    .extResync(extResync), .redOut_ff(redOut), .greenOut_ff(greenOut), .blueOut_ff(blueOut),
    .hires_nibble_out(nibble), .overlay_select_n_ff(overlayN), .hsyncN_ff(hsyncN),
    .vert_or_composite_sync_ff(syncPin), .vertical_retrace_flag_ff(flyback),
    .videoRequest_ff(vreq), .cursorRequest_ff(creq));
  vssc_far_model i_far (.clock(clock), .nibble(nibble), .resyncReq(resyncReq),
    .extResync(extResync), .serialBit());

  always #2 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Expected DAC code: first revision drives the inverse
  function automatic logic [3:0] dacCode(input logic [3:0] v, input logic rev2);
    return rev2 ? v : ~v;
  endfunction
  // Fresh random pixels every cycle; hires keeps identity palette and ties cursor colour bits 5:4 to the pixel code
  always @(posedge clock) begin
    seed <= xs(seed);
    if (hiresOn) begin
      videoColour <= {seed[12], 8'h00, seed[3:0]};
      cursorPixel <= {seed[14], seed[14] | seed[13]}; // Code 10 never sent
      cursorColour <= {seed[28], 6'h00, seed[14], seed[14] | seed[13], 4'h0};
    end else begin
      videoColour <= seed[12:0];
      cursorPixel <= seed[14:13];
      cursorColour <= seed[28:16];
    end
  end
  // Event counters over a measuring window
  always @(posedge clock) begin
    prevPin <= syncPin;
    if (monOn) begin
      vreqN += vreq;
      creqN += creq;
      flyLowN += !flyback;
      edgeN += (syncPin !== prevPin);
      redN += ({blueOut, greenOut, redOut} === colWant);
      supN += !overlayN;
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Each channel is released at the edge where its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic run(input int n);
    vreqN = 0;
    creqN = 0;
    flyLowN = 0;
    edgeN = 0;
    redN = 0;
    supN = 0;
    monOn <= 1'b1;
    repeat (n) @(posedge clock);
    monOn <= 1'b0;
  endtask
  // Resync pulse launched just after a line sync edge
  task automatic resync();
    @(negedge hsyncN);
    @(posedge clock);
    resyncReq <= 1'b1;
    @(posedge clock);
    resyncReq <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    rd(`VSSC_OFF_STATUS, d, r);
    check("flyback at reset", d[19], 32'h1);
    rd(8'h50, d, r);
    check("unmapped read", r, `VSSC_RESP_SLVERR);
    wr(`VSSC_OFF_STATUS, 32'h1, r);
    check("status write", r, `VSSC_RESP_SLVERR);
    // Timing is loaded while the screen is still off, so inside flyback
    for (int i = 0; i < 16; i++) begin
      wr(cfgA[i], cfgD[i], r);
      check("config write", r, `VSSC_RESP_OK);
    end
    run(700);
    check("video requests", vreqN > 0, 32'h1);
    check("flyback low", flyLowN > 0, 32'h1);
    check("cursor requests", creqN > 0, 32'h1);
    wr(`VSSC_OFF_VBSTART, 32'h8, r);
    run(700);
    check("cursor requests border off", creqN > 0, 32'h1);
    wr(`VSSC_OFF_VCEND, 32'h0, r);
    run(700);
    check("cursor requests cursor off", creqN, 32'h0);
    wr(`VSSC_OFF_VBSTART, 32'h0, r);
    wr(`VSSC_OFF_VBEND, 32'h9, r);
    wr(`VSSC_OFF_VDEND, 32'h1, r);
    colWant = {dacCode(4'h0, 1'b0), dacCode(4'hA, 1'b0), dacCode(4'h5, 1'b0)};
    run(700);
    check("video requests screen off", vreqN, 32'h0);
    check("border colour first revision", redN > 0, 32'h1);
    check("border overlay", supN > 0, 32'h1);
    wr(`VSSC_OFF_CTRL, 32'h280, r);
    colWant = {dacCode(4'h0, 1'b1), dacCode(4'hA, 1'b1), dacCode(4'h5, 1'b1)};
    run(400);
    check("border colour second revision", redN > 0, 32'h1);
    check("composite edges", edgeN > 6, 32'h1);
    resync();
    repeat (3) @(negedge hsyncN);
    rd(`VSSC_OFF_STATUS, d, r);
    check("rasters after resync", d[15:6], 32'h3);
    wr(`VSSC_OFF_CTRL, 32'h2C0, r); // Vertical cycle 9 frames 21 rasters
    resync();
    repeat (3) @(posedge clock);
    rd(`VSSC_OFF_STATUS, d, r);
    check("odd field after resync", d[18], 32'h1);
    // Hires on a straight DAC: white cursor is the only way to show red F alone
    wr(`VSSC_OFF_CTRL, 32'h300, r);
    hiresOn <= 1'b1;
    wr(`VSSC_OFF_BORDER, 32'h1005, r);
    wr(`VSSC_OFF_VCEND, 32'h5, r);
    colWant = 12'h00F;
    run(700);
    check("hires cursor white", redN > 0, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
